// >>> hw/srd_host_decode.sv
// Host slave address decode for the four mapping modes
`timescale 1ns/1ps
module srd_host_decode (
  // Clock and reset, used by checks only
  input wire logic clk,
  input wire logic srst,
  // Decode inputs
  input wire srd_pkg::srd_map_t mode,
  input wire srd_pkg::srd_host_req_t req,
  input wire logic [srd_pkg::WORD_W-1:0] memory_index_shadow,
  // Decode result
  output srd_pkg::srd_dec_t dec
);
  import srd_pkg::*;

  logic [REG_OFF_W-1:0] off;
  logic in_upper;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  always_comb begin
    off = req.addr[REG_OFF_W-1:0];
    in_upper = (off >= UPPER_LO) && (off <= UPPER_HI);
    dec = '0;
    dec.reg_off = off;
    case (mode)
      MAP_INDEX: begin
        if (req.cs && in_upper) begin
          dec.mem_hit = 1'b1; // R6
          dec.word = memory_index_shadow
            + WORD_W'((off - UPPER_LO) >> WORD_LSB); // R5
        end else begin
          dec.reg_hit = req.cs;
        end
      end
      MAP_WIDE: begin
        if (req.cs && req.addr[HOST_RAM_BIT]) begin
          dec.mem_hit = 1'b1; // R11
          dec.word = host_word(req.addr); // R9
        end else begin
          dec.reg_hit = req.cs; // R10
        end
      end
      MAP_SELECT: begin
        dec.mem_hit = !req.memory_select_n; // R13
        dec.word = host_word(req.addr);
        dec.reg_hit = req.cs && req.memory_select_n;
      end
      default: begin
        dec.reg_hit = req.cs; // R14
      end
    endcase
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_wide_alias: assert property ( // R10
    (mode == MAP_WIDE && req.cs && !req.addr[HOST_RAM_BIT])
      |-> (dec.reg_hit && !dec.mem_hit
           && dec.reg_off == req.addr[REG_OFF_W-1:0]))
    else $error("wide mode register alias wrong");
  a_wide_mem: assert property ( // R11
    (mode == MAP_WIDE && req.cs && req.addr[HOST_RAM_BIT])
      |-> (dec.mem_hit && dec.word == req.addr[WORD_MSB:WORD_LSB]))
    else $error("wide mode memory decode wrong");
  a_sel_regs: assert property ( // R13
    (mode == MAP_SELECT && req.cs && req.memory_select_n)
      |-> (dec.reg_hit && !dec.mem_hit))
    else $error("chip select reached memory in select mode");
  a_none_unmapped: assert property ( // R14
    (mode == MAP_NONE) |-> !dec.mem_hit)
    else $error("memory visible while unmapped");
endmodule

// >>> hw/srd_ram.sv
// Single-port 1K x 32 script memory with registered read
`timescale 1ns/1ps
module srd_ram (
  // Clock
  input wire logic clk,
  // Access port
  input wire logic en,
  input wire logic we,
  input wire logic [srd_pkg::WORD_W-1:0] word,
  input wire logic [srd_pkg::DATA_W-1:0] wdata,
  output logic [srd_pkg::DATA_W-1:0] rdata
);
  import srd_pkg::*;

  logic [DATA_W-1:0] mem [RAM_WORDS];

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (en && we) begin
      mem[word] <= wdata;
    end
    if (en) begin
      rdata <= mem[word];
    end
  end
endmodule

// >>> hw/srd_top.sv
// Internal script memory with script/host arbitration and decode
`timescale 1ns/1ps
// What this block does
// (R1) Holds 1024 words of 32 bits
// (R2) Script fetches in range read internally, no bus
// (R3) Other internal-memory accesses go out as bus cycles
// (R4) Base address from base shadow when bit0 set
// (R5) Index mode addresses memory via index shadow
// (R6) Index mode memory replaces upper scratch bank
// (R7) Index mode refuses host while script runs
// (R8) Own read-modify-write and moves may write memory
// (R9) Wide mode: 4K registers plus 4K memory
// (R10) Wide mode registers alias every 128 bytes
// (R11) Wide mode memory at 1000h to 1FFFh
// (R12) Host collisions stretch at most seven waits
// (R13) Select mode: memory select pin, chip select registers
// (R14) Both bits clear: memory hidden from host
module srd_top (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Configuration
  input wire logic ram_enable,
  input wire logic [2:0] memory_config_register,
  input wire logic [31:0] memory_base_shadow,
  input wire logic [srd_pkg::WORD_W-1:0] memory_index_shadow,
  input wire logic script_running,
  // Script processor side
  input wire srd_pkg::srd_scr_req_t scr_req,
  output logic scr_ready,
  output logic scr_to_bus,
  output logic scr_ack,
  output logic [srd_pkg::DATA_W-1:0] scr_rdata,
  // Host slave side
  input wire srd_pkg::srd_host_req_t host_req,
  output logic host_ready,
  output logic host_refused,
  output logic host_reg_sel,
  output logic [srd_pkg::REG_OFF_W-1:0] host_reg_off,
  output logic [srd_pkg::DATA_W-1:0] host_rdata
);
  import srd_pkg::*;

  typedef enum logic [3:0] {
    H_IDLE = 4'h1,
    H_ARB = 4'h2,
    H_READ = 4'h4,
    H_DONE = 4'h8
  } srd_hstate_t;

  srd_map_t mode;
  srd_dec_t dec;
  srd_hstate_t state;
  srd_hstate_t next_state;
  logic [2:0] waits;
  logic [2:0] next_waits;
  logic refused;
  logic next_refused;
  logic reg_sel;
  logic next_reg_sel;
  logic [REG_OFF_W-1:0] next_reg_off;
  logic [DATA_W-1:0] next_host_rdata;
  logic [WORD_W-1:0] hword;
  logic [WORD_W-1:0] next_hword;
  logic scr_pend;
  logic next_scr_pend;
  logic scr_in_range;
  logic scr_fetch;
  logic scr_use;
  logic host_force;
  logic host_grant;
  logic ram_en;
  logic ram_we;
  logic [WORD_W-1:0] ram_word;
  logic [DATA_W-1:0] ram_rdata;
  logic host_blocked;

  assign mode = cfg_mode(memory_config_register);

  // ----------------------------------------
  // Parts
  // ----------------------------------------
  srd_host_decode srd_host_decode_inst (
    .clk(clk),
    .srst(srst),
    .mode(mode),
    .req(host_req),
    .memory_index_shadow(memory_index_shadow),
    .dec(dec)
  );

  srd_ram srd_ram_inst ( // R1
    .clk(clk),
    .en(ram_en),
    .we(ram_we),
    .word(ram_word),
    .wdata(host_req.wdata),
    .rdata(ram_rdata)
  );

  // ----------------------------------------
  // Script side decode
  // ----------------------------------------
  always_comb begin
    // Without the base bit the script never sees the memory
    scr_in_range = ram_enable && memory_config_register[CFG_BASE_BIT]
      && (scr_req.addr[31:SCR_BASE_LSB]
          == memory_base_shadow[31:SCR_BASE_LSB]); // R4
    scr_fetch = scr_req.kind != KIND_OTHER;
    host_force = (state == H_ARB) && (waits == MAX_WAIT);
    scr_use = scr_req.valid && scr_in_range && scr_fetch
      && !host_force; // R2
    // Stall only internal fetches, and only when host has waited out
    scr_ready = !(scr_req.valid && scr_in_range && scr_fetch
      && host_force);
    scr_to_bus = scr_req.valid && !(scr_in_range && scr_fetch); // R3
    host_grant = (state == H_ARB) && !scr_use;
    ram_en = scr_use || host_grant;
    ram_we = host_grant && host_req.we;
    ram_word = scr_use ? scr_req.addr[WORD_MSB:WORD_LSB] : hword;
  end

  always_comb begin
    next_scr_pend = scr_use;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      scr_pend <= 1'b0;
    end else begin
      scr_pend <= next_scr_pend;
    end
  end

  assign scr_ack = scr_pend;
  assign scr_rdata = ram_rdata;

  // ----------------------------------------
  // Host side sequencing
  // ----------------------------------------
  always_comb begin
    // Own master cycles carry the script's writes, so never refused
    host_blocked = (mode == MAP_INDEX) && script_running
      && !host_req.own_master; // R7 R8
    next_state = state;
    next_waits = waits;
    next_refused = refused;
    next_reg_sel = reg_sel;
    next_reg_off = host_reg_off;
    next_host_rdata = host_rdata;
    next_hword = hword;
    case (state)
      H_IDLE: begin
        next_waits = '0;
        next_refused = 1'b0;
        next_reg_sel = 1'b0;
        // Refused accesses answer at once, with zero data
        if (dec.mem_hit && host_blocked) begin
          next_refused = 1'b1; // R7
          next_host_rdata = '0;
          next_state = H_DONE;
        end else if (dec.mem_hit) begin
          next_hword = dec.word;
          next_state = H_ARB;
        end else if (dec.reg_hit) begin
          next_reg_sel = 1'b1;
          next_reg_off = dec.reg_off;
          next_host_rdata = '0;
          next_state = H_DONE;
        end
      end
      H_ARB: begin
        // Script keeps priority; the wait count bounds the host delay
        if (host_grant) begin
          next_state = H_READ;
        end else begin
          next_waits = waits + 3'h1; // R12
        end
      end
      H_READ: begin
        next_host_rdata = ram_rdata;
        next_state = H_DONE;
      end
      H_DONE: begin
        next_state = H_IDLE;
      end
      default: begin
        next_state = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= H_IDLE;
      waits <= '0;
      refused <= 1'b0;
      reg_sel <= 1'b0;
      host_reg_off <= '0;
      host_rdata <= '0;
      hword <= '0;
    end else begin
      state <= next_state;
      waits <= next_waits;
      refused <= next_refused;
      reg_sel <= next_reg_sel;
      host_reg_off <= next_reg_off;
      host_rdata <= next_host_rdata;
      hword <= next_hword;
    end
  end

  assign host_ready = state == H_DONE;
  assign host_refused = host_ready && refused;
  assign host_reg_sel = host_ready && reg_sel;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_fetch_hit;
    scr_req.valid && scr_in_range && scr_fetch && scr_ready;
  endsequence

  a_hit_no_bus: assert property ( // R2
    s_fetch_hit |-> (!scr_to_bus ##1 scr_ack))
    else $error("internal fetch went out or was not answered");
  a_other_bus: assert property ( // R3
    (scr_req.valid && scr_req.kind == KIND_OTHER) |-> scr_to_bus)
    else $error("non-fetch access kept internal");
  a_base_gate: assert property ( // R4
    (scr_req.valid && !memory_config_register[CFG_BASE_BIT])
      |-> !scr_use)
    else $error("script hit without base enable");
  a_refuse_run: assert property ( // R7
    (state == H_IDLE && dec.mem_hit && mode == MAP_INDEX
      && script_running && !host_req.own_master)
      |=> (host_ready && host_refused))
    else $error("host not refused while script runs");
  a_own_write: assert property ( // R8
    (state == H_IDLE && dec.mem_hit && host_req.own_master)
      |=> (state == H_ARB))
    else $error("own memory move blocked");

  sequence s_arb_start;
    state == H_IDLE && dec.mem_hit && !host_blocked;
  endsequence

  a_wait_bound: assert property ( // R12
    s_arb_start |=> ##[1:8] (state == H_READ) ##1 host_ready)
    else $error("host stretched beyond seven waits");
  a_wide_window: assert property ( // R9
    (state == H_ARB && mode == MAP_WIDE && !scr_use)
      |-> (ram_word == hword && ram_en))
    else $error("wide mode host access not served");

  // ----------------------------------------
  // Handshake checks
  // ----------------------------------------
  // A ready held over two edges would close two accesses at once
  a_ready_pulse: assert property ( // R12
    host_ready |=> !host_ready)
    else $error("host ready held for more than one cycle");

  // The seventh wait must hand the memory to the host
  a_force_grant: assert property ( // R12
    host_force |-> (host_grant && !scr_use))
    else $error("host not served after seven waits");

  a_bus_no_ack: assert property ( // R3
    (scr_req.valid && scr_to_bus) |=> !scr_ack)
    else $error("bus cycle also answered internally");

  a_ack_single: assert property ( // R2
    scr_ack |-> $past(scr_use))
    else $error("script answer without an internal fetch");

  sequence s_reg_take;
    state == H_IDLE && !dec.mem_hit && dec.reg_hit;
  endsequence

  a_reg_answer: assert property ( // R14
    s_reg_take |=> (host_ready && host_reg_sel && !host_refused))
    else $error("register access not answered next cycle");

  sequence s_index_take;
    state == H_IDLE && mode == MAP_INDEX && dec.mem_hit
      && !host_blocked;
  endsequence

  a_index_word: assert property ( // R5
    s_index_take |=> (state == H_ARB && hword == $past(dec.word)))
    else $error("index mode word not captured");

  // A refused access must never have reached the grant state
  a_refuse_nowrite: assert property ( // R7
    host_refused |-> ($past(state) == H_IDLE && !$past(ram_we)))
    else $error("refused access touched the memory");

  a_host_write: assert property ( // R8
    (state == H_ARB && host_grant)
      |-> (ram_we == host_req.we && ram_word == hword))
    else $error("host access not applied at grant");
endmodule

// >>> shared/srd_pkg.sv
// Shared constants, types and helpers for the internal script memory block
package srd_pkg;
  // ----------------------------------------
  // Memory geometry
  // ----------------------------------------
  localparam int RAM_WORDS = 1024;
  localparam int WORD_W = 10;
  localparam int DATA_W = 32;
  localparam int HOST_AW = 13;
  localparam int REG_OFF_W = 7;
  // ----------------------------------------
  // Configuration bit positions
  // ----------------------------------------
  localparam int CFG_BASE_BIT = 0;
  localparam int CFG_INDEX_BIT = 1;
  localparam int CFG_WIDE_BIT = 2;
  // ----------------------------------------
  // Address fields
  // ----------------------------------------
  localparam int HOST_RAM_BIT = 12;
  localparam int WORD_LSB = 2;
  localparam int WORD_MSB = 11;
  localparam int SCR_BASE_LSB = 12;
  localparam logic [6:0] UPPER_LO = 7'h60;
  localparam logic [6:0] UPPER_HI = 7'h7F;
  // ----------------------------------------
  // Arbitration
  // ----------------------------------------
  localparam logic [2:0] MAX_WAIT = 3'h7;
  // ----------------------------------------
  // Script access kinds
  // ----------------------------------------
  localparam logic [1:0] KIND_OPCODE = 2'h0;
  localparam logic [1:0] KIND_INDIRECT = 2'h1;
  localparam logic [1:0] KIND_TABLE = 2'h2;
  localparam logic [1:0] KIND_OTHER = 2'h3;

  typedef enum logic [3:0] {
    MAP_NONE = 4'h1,
    MAP_INDEX = 4'h2,
    MAP_WIDE = 4'h4,
    MAP_SELECT = 4'h8
  } srd_map_t;

  typedef struct packed {
    logic valid;
    logic [1:0] kind;
    logic [31:0] addr;
  } srd_scr_req_t;

  typedef struct packed {
    logic cs;
    logic memory_select_n;
    logic own_master;
    logic we;
    logic [HOST_AW-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } srd_host_req_t;

  typedef struct packed {
    logic mem_hit;
    logic reg_hit;
    logic [WORD_W-1:0] word;
    logic [REG_OFF_W-1:0] reg_off;
  } srd_dec_t;

  function automatic srd_map_t cfg_mode(input logic [2:0] cfg);
    if (cfg[CFG_WIDE_BIT] && cfg[CFG_INDEX_BIT]) begin
      return MAP_SELECT;
    end else if (cfg[CFG_WIDE_BIT]) begin
      return MAP_WIDE;
    end else if (cfg[CFG_INDEX_BIT]) begin
      return MAP_INDEX;
    end
    return MAP_NONE;
  endfunction

  function automatic logic [WORD_W-1:0] host_word(
    input logic [HOST_AW-1:0] a);
    return a[WORD_MSB:WORD_LSB];
  endfunction
endpackage

// >>> tb/srd_host_model.sv
// Host bus master model for slave accesses
`timescale 1ns/1ps
module srd_host_model (
  // Clock
  input wire logic clk,
  // Block host port
  output srd_pkg::srd_host_req_t host_req,
  input wire logic host_ready,
  input wire logic host_refused,
  input wire logic host_reg_sel,
  input wire logic [srd_pkg::REG_OFF_W-1:0] host_reg_off,
  input wire logic [srd_pkg::DATA_W-1:0] host_rdata
);
  import srd_pkg::*;
  logic [1:0] fl;
  logic [31:0] rd;
  logic [6:0] off;
  int waits;
  initial host_req = '{1'b0, 1'b1, 1'b0, 1'b0, '0, '0};
  // Released lines flip, so stale values never pass for a match
  task automatic acc(input logic cs, input logic sn, input logic own,
    input logic we, input logic [HOST_AW-1:0] a, input logic [31:0] d);
    // One idle edge between accesses, so no line changes twice a step
    @(posedge clk);
    #1;
    host_req = '{cs, sn, own, we, a, d};
    waits = 0;
    do begin
      @(negedge clk);
      waits++;
    end while (!host_ready && waits < 20);
    fl = {host_refused, host_reg_sel};
    rd = host_rdata;
    off = host_reg_off;
    @(posedge clk);
    #1;
    host_req = '{1'b0, 1'b1, 1'b0, we, ~a, ~d};
  endtask
endmodule

// >>> tb/srd_top_tb.sv
// Self-checking bench for the script memory block
`timescale 1ns/1ps
module srd_top_tb;
  import srd_pkg::*;
  logic clk, srst, ram_enable, run;
  logic [2:0] cfg;
  logic [31:0] base;
  logic [WORD_W-1:0] idx;
  srd_scr_req_t scr_req;
  logic scr_ready, scr_to_bus, scr_ack;
  logic [31:0] scr_rdata, host_rdata;
  srd_host_req_t host_req;
  logic host_ready, host_refused, host_reg_sel;
  logic [REG_OFF_W-1:0] host_reg_off;
  int n_fail, checked;
  int wl[4] = '{0, 1, 2, 1023};
  int stalls = 0;

  srd_top srd_top_inst (.clk(clk), .srst(srst), .ram_enable(ram_enable),
    .memory_config_register(cfg), .memory_base_shadow(base),
    .memory_index_shadow(idx), .script_running(run), .scr_req(scr_req),
    .scr_ready(scr_ready), .scr_to_bus(scr_to_bus), .scr_ack(scr_ack),
    .scr_rdata(scr_rdata), .host_req(host_req), .host_ready(host_ready),
    .host_refused(host_refused), .host_reg_sel(host_reg_sel),
    .host_reg_off(host_reg_off), .host_rdata(host_rdata));
  srd_host_model srd_host_model_inst (.clk(clk), .host_req(host_req),
    .host_ready(host_ready), .host_refused(host_refused),
    .host_reg_sel(host_reg_sel), .host_reg_off(host_reg_off),
    .host_rdata(host_rdata));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Script stall cycles, counted where the strobe has settled
  always @(negedge clk) begin
    if (!srst && scr_ready !== 1'b1) stalls++;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    if (n_fail == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic h(input logic cs, input logic sn, input logic own,
    input logic we, input logic [12:0] a, input logic [31:0] d);
    srd_host_model_inst.acc(cs, sn, own, we, a, d);
  endtask

  // Flags are {refused, reg_sel}; w of 0 skips the latency
  task automatic hres(input logic [1:0] f, input logic [31:0] d,
    input int w);
    chk({30'h0, srd_host_model_inst.fl}, {30'h0, f});
    if (d !== 32'hX) chk(srd_host_model_inst.rd, d);
    if (w > 0) chk(srd_host_model_inst.waits, w);
  endtask

  // Bus fetches must raise the bus flag and never acknowledge
  task automatic fetch(input logic [1:0] k, input logic [31:0] a,
    input logic bus, input logic [31:0] d);
    scr_req = '{1'b1, k, a};
    @(negedge clk);
    chk({31'h0, scr_to_bus}, {31'h0, bus});
    @(posedge clk);
    #1;
    chk({31'h0, scr_ack}, {31'h0, !bus});
    if (!bus) chk(scr_rdata, d);
    scr_req = '{1'b0, k, ~a};
    @(posedge clk);
    #1;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic wide_mode;
    cfg = 3'b101;
    foreach (wl[i]) begin
      h(1, 1, 0, 1, 13'(32'h1000 + 4 * wl[i]), 32'hA500_0000 + wl[i]);
    end
    foreach (wl[i]) begin
      h(1, 1, 0, 0, 13'(32'h1000 + 4 * wl[i]), 32'h0);
      hres(2'b00, 32'hA500_0000 + wl[i], 4);
    end
    h(1, 1, 0, 0, 13'h0FA4, 32'h0);
    hres(2'b01, 32'h0, 2);
    chk({25'h0, srd_host_model_inst.off}, 32'h24);
  endtask

  task automatic script_fetch;
    fetch(KIND_OPCODE, 32'h0004_5000, 0, 32'hA500_0000);
    fetch(KIND_INDIRECT, 32'h0004_5FFC, 0, 32'hA500_03FF);
    fetch(KIND_TABLE, 32'h0004_5008, 0, 32'hA500_0002);
    fetch(KIND_OTHER, 32'h0004_5000, 1, 32'h0);
    fetch(KIND_OPCODE, 32'h0004_6000, 1, 32'h0);
    cfg = 3'b100;
    fetch(KIND_OPCODE, 32'h0004_5000, 1, 32'h0);
    cfg = 3'b101;
    ram_enable = 1'b0;
    fetch(KIND_OPCODE, 32'h0004_5000, 1, 32'h0);
    ram_enable = 1'b1;
  endtask

  // Script keeps fetching while the host reads
  task automatic collide;
    scr_req = '{1'b1, KIND_OPCODE, 32'h0004_5000};
    h(1, 1, 0, 0, 13'h1004, 32'h0);
    scr_req.valid = 1'b0;
    hres(2'b00, 32'hA500_0001, 0);
    chk({31'h0, srd_host_model_inst.waits <= 11}, 32'h1);
    chk(stalls, 32'h1);
  endtask

  task automatic select_none;
    cfg = 3'b111;
    h(0, 0, 0, 0, 13'h0008, 32'h0);
    hres(2'b00, 32'hA500_0002, 4);
    h(1, 1, 0, 0, 13'h1000, 32'h0);
    hres(2'b01, 32'h0, 2);
    cfg = 3'b001;
    h(1, 1, 0, 0, 13'h1000, 32'h0);
    hres(2'b01, 32'h0, 2);
  endtask

  task automatic index_mode;
    cfg = 3'b011;
    idx = 10'h001;
    h(1, 1, 0, 0, 13'h0064, 32'h0);
    hres(2'b00, 32'hA500_0002, 4);
    h(1, 1, 0, 0, 13'h005C, 32'h0);
    hres(2'b01, 32'h0, 2);
    run = 1'b1;
    h(1, 1, 0, 1, 13'h0064, 32'h1111_0000);
    hres(2'b10, 32'h0, 2);
    h(1, 1, 1, 1, 13'h0068, 32'h2222_0000);
    run = 1'b0;
    h(1, 1, 0, 0, 13'h0064, 32'h0);
    hres(2'b00, 32'hA500_0002, 4);
    h(1, 1, 0, 0, 13'h0068, 32'h0);
    hres(2'b00, 32'h2222_0000, 4);
  endtask

  // Reset in mid-run clears the answer fields, not the memory
  task automatic reset_mid;
    srst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(host_rdata, 32'h0);
    chk({25'h0, host_reg_off}, 32'h0);
    srst = 1'b0;
    h(1, 1, 0, 0, 13'h0068, 32'h0);
    hres(2'b00, 32'h2222_0000, 4);
  endtask

  initial begin
    n_fail = 0;
    checked = 0;
    srst = 1'b1;
    ram_enable = 1'b1;
    run = 1'b0;
    cfg = 3'b000;
    base = 32'h0004_5000;
    idx = '0;
    scr_req = '0;
    repeat (10) @(posedge clk);
    #1;
    chk({28'h0, host_ready, host_refused, host_reg_sel, scr_ack}, 32'h0);
    chk(host_rdata, 32'h0);
    srst = 1'b0;
    wide_mode();
    script_fetch();
    collide();
    select_none();
    index_mode();
    reset_mid();
    finish_test();
  end

  // Whole run is under two hundred cycles
  initial begin
    #200000;
    n_fail++;
    finish_test();
  end
endmodule
